// ---- rtl/emsc_pkg.sv ----
// Package for the event mask and suspend control block.
// Assumes a plain register port with word indices; clock MCLK at 125 MHz.
package emsc_pkg;
   localparam logic [3:0] ADDR_EVENT = 4'h4;
   localparam logic [3:0] ADDR_CTRL1 = 4'h5;
   localparam logic [3:0] ADDR_CTRL0 = 4'h0;
   localparam logic [3:0] ADDR_RESET_REG = 4'h8;
   localparam int BIT_RCO = 5;
   localparam int BIT_RCOM = 4;
   localparam int BIT_TXB = 3;
   localparam int BIT_TXBM = 2;
   localparam int BIT_JAB = 1;
   localparam int BIT_TRANSMIT_RUNAWAY_MASK = 0;
   localparam int BIT_SUSPEND = 0;
   localparam int BIT_STOP = 2;
   localparam int BIT_INTERRUPT_OUTPUT_ENABLE = 6;
   localparam int BIT_INTERRUPT_SUMMARY_FLAG = 7;
   localparam logic [15:0] EVENT_RESET = 16'h0015;
   localparam logic [15:0] EVENT_WMASK = 16'h0015;
   localparam logic [15:0] EVENT_W1C = 16'h002A;
   typedef enum logic [1:0] {EMSC_ACTIVE, EMSC_TX_DRAIN, EMSC_RX_DRAIN, EMSC_SUSPENDED} emsc_state_t;
endpackage

// ---- rtl/emsc_top.sv ----
// Event flags, masks and suspend control of an Ethernet controller.
// Assumes synchronous inputs from MAC, transceiver and collision counter.
// Notes on behaviour
// - Collision counter wrap sets overflow flag.
// - Overflow flag clears by write-one, reset, stop.
// - Overflow mask gates summary; reset sets it.
// - Frame start sets transmit-begun flag.
// - Interrupt needs enable and clear transmit mask.
// - Transmit-begun flag clears by write-one, reset, stop.
// - Transmit mask gates summary; reset sets it.
// - Runaway flag set only with twisted pair.
// - Interrupt needs enable and clear runaway mask.
// - Runaway flag clears despite persisting condition.
// - Runaway mask gates summary; reset sets it.
// - Reserved bits seven and six read zero.
// - Suspend accepts one only while stop clear.
// - Writing zero to suspend resumes operation.
// - Reset, reset-register read, stop leave suspend.
// - Suspended device ignores incoming frames silently.
// - Registers stay accessible while suspended.
// - Resume continues at paused ring positions.
//
// The strobed register port and the address map were decided locally.
module emsc_top (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   input wire logic COLL_WRAP,
   input wire logic TX_START,
   input wire logic JABBER,
   input wire logic TP_ACTIVE,
   input wire logic TX_BUSY,
   input wire logic RX_BUSY,
   output logic IRQ,
   output logic SUSPENDED,
   output logic RX_BLOCK,
   output logic HOLD_RINGS,
   output logic STOP_OUT
);
   typedef struct packed {
      logic [15:0] rdata;
      logic [5:0] ev;
      logic stop;
      logic interrupt_output_enable;
      logic suspend_request_req;
      emsc_pkg::emsc_state_t st;
      logic irq;
      logic suspended;
      logic rx_block;
      logic hold_rings;
      logic jab_prev;
   } emsc_s_t;

   emsc_s_t s_ff;
   emsc_s_t nxt_s;

   function automatic logic summary(input logic [5:0] ev);
      summary = (ev[emsc_pkg::BIT_RCO] & ~ev[emsc_pkg::BIT_RCOM])
              | (ev[emsc_pkg::BIT_TXB] & ~ev[emsc_pkg::BIT_TXBM])
              | (ev[emsc_pkg::BIT_JAB] & ~ev[emsc_pkg::BIT_TRANSMIT_RUNAWAY_MASK]);
   endfunction

   logic wr_ev, wr_c1, wr_c0, rst_rd, kick, interrupt_summary_flag;
   logic [5:0] setv;

   always_comb begin
      nxt_s = s_ff;
      wr_ev = WR && ADDR == emsc_pkg::ADDR_EVENT;
      wr_c1 = WR && ADDR == emsc_pkg::ADDR_CTRL1;
      wr_c0 = WR && ADDR == emsc_pkg::ADDR_CTRL0;
      rst_rd = RD && ADDR == emsc_pkg::ADDR_RESET_REG;
      setv = '0;
      setv[emsc_pkg::BIT_RCO] = COLL_WRAP;
      setv[emsc_pkg::BIT_TXB] = TX_START;
      // Only the onset of runaway sets the flag, so a written one clears it while it lasts.
      setv[emsc_pkg::BIT_JAB] = JABBER && TP_ACTIVE && !s_ff.jab_prev;
      nxt_s.jab_prev = JABBER && TP_ACTIVE;
      if (wr_c0) begin
         nxt_s.stop = WDATA[emsc_pkg::BIT_STOP];
         nxt_s.interrupt_output_enable = WDATA[emsc_pkg::BIT_INTERRUPT_OUTPUT_ENABLE];
      end
      kick = rst_rd || (wr_c0 && WDATA[emsc_pkg::BIT_STOP]);
      if (wr_ev) begin
         // Masks are plain writes; flags clear on written ones.
         nxt_s.ev = (s_ff.ev & ~emsc_pkg::EVENT_WMASK[5:0])
                  | (WDATA[5:0] & emsc_pkg::EVENT_WMASK[5:0]);
         nxt_s.ev = nxt_s.ev & ~(WDATA[5:0] & emsc_pkg::EVENT_W1C[5:0]);
      end
      if (kick) begin
         // Stop and reset-register read clear flags but keep masks.
         nxt_s.ev = nxt_s.ev & emsc_pkg::EVENT_WMASK[5:0];
      end
      nxt_s.ev = nxt_s.ev | setv; // Set wins over clear.
      if (wr_c1) begin
         nxt_s.suspend_request_req = WDATA[emsc_pkg::BIT_SUSPEND] && !s_ff.stop;
      end
      unique case (s_ff.st)
         emsc_pkg::EMSC_ACTIVE: begin
            // A new request always starts with the transmit drain.
            if (nxt_s.suspend_request_req) begin
               nxt_s.st = emsc_pkg::EMSC_TX_DRAIN;
            end
         end
         emsc_pkg::EMSC_TX_DRAIN: begin
            if (!TX_BUSY) begin
               nxt_s.st = emsc_pkg::EMSC_RX_DRAIN;
            end
         end
         emsc_pkg::EMSC_RX_DRAIN: begin
            if (!RX_BUSY) begin
               nxt_s.st = emsc_pkg::EMSC_SUSPENDED;
            end
         end
         emsc_pkg::EMSC_SUSPENDED: begin
            nxt_s.st = emsc_pkg::EMSC_SUSPENDED;
         end
      endcase
      if (!nxt_s.suspend_request_req) begin
         nxt_s.st = emsc_pkg::EMSC_ACTIVE;
      end
      if (kick) begin
         nxt_s.suspend_request_req = 1'b0;
         nxt_s.st = emsc_pkg::EMSC_ACTIVE;
      end
      // Status outputs are registered copies of the next state.
      nxt_s.suspended = nxt_s.st == emsc_pkg::EMSC_SUSPENDED;
      nxt_s.rx_block = nxt_s.st == emsc_pkg::EMSC_SUSPENDED;
      nxt_s.hold_rings = nxt_s.st != emsc_pkg::EMSC_ACTIVE;
      interrupt_summary_flag = summary(nxt_s.ev);
      nxt_s.irq = interrupt_summary_flag && nxt_s.interrupt_output_enable;
      nxt_s.rdata = '0;
      if (RD) begin
         unique case (ADDR)
            emsc_pkg::ADDR_EVENT: nxt_s.rdata = {10'h000, s_ff.ev};
            emsc_pkg::ADDR_CTRL1: begin
               nxt_s.rdata[emsc_pkg::BIT_SUSPEND] = s_ff.suspended;
            end
            emsc_pkg::ADDR_CTRL0: begin
               nxt_s.rdata[emsc_pkg::BIT_STOP] = s_ff.stop;
               nxt_s.rdata[emsc_pkg::BIT_INTERRUPT_OUTPUT_ENABLE] = s_ff.interrupt_output_enable;
               nxt_s.rdata[emsc_pkg::BIT_INTERRUPT_SUMMARY_FLAG] = summary(s_ff.ev);
            end
            default: nxt_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         s_ff <= '{rdata: 16'h0000, ev: emsc_pkg::EVENT_RESET[5:0], stop: 1'b1, interrupt_output_enable: 1'b0,
                   suspend_request_req: 1'b0, st: emsc_pkg::EMSC_ACTIVE, irq: 1'b0, suspended: 1'b0,
                   rx_block: 1'b0, hold_rings: 1'b0, jab_prev: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign RDATA = s_ff.rdata;
   assign IRQ = s_ff.irq;
   assign SUSPENDED = s_ff.suspended;
   assign RX_BLOCK = s_ff.rx_block;
   assign HOLD_RINGS = s_ff.hold_rings;
   assign STOP_OUT = s_ff.stop;

   // Collision overflow flag and its mask.
   AST_RCO_SET: assert property (@(posedge MCLK) disable iff (!RST_B)
      COLL_WRAP
      |=> s_ff.ev[emsc_pkg::BIT_RCO])
      else $error("overflow flag not set");

   AST_RCO_W1C: assert property (@(posedge MCLK) disable iff (!RST_B)
      wr_ev && WDATA[emsc_pkg::BIT_RCO] && !COLL_WRAP
      |=> !s_ff.ev[emsc_pkg::BIT_RCO])
      else $error("overflow write one did not clear");

   AST_RCO_W0: assert property (@(posedge MCLK) disable iff (!RST_B)
      wr_ev && !WDATA[emsc_pkg::BIT_RCO] && s_ff.ev[emsc_pkg::BIT_RCO] && !kick
      |=> s_ff.ev[emsc_pkg::BIT_RCO])
      else $error("overflow write zero cleared");

   AST_RCO_STOP: assert property (@(posedge MCLK) disable iff (!RST_B)
      kick && !COLL_WRAP
      |=> !s_ff.ev[emsc_pkg::BIT_RCO])
      else $error("overflow survived stop");

   AST_RCOM_GATE: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_ff.ev[emsc_pkg::BIT_RCOM] && !s_ff.ev[emsc_pkg::BIT_TXB] && !s_ff.ev[emsc_pkg::BIT_JAB]
      |-> !IRQ)
      else $error("masked overflow raised irq");

   AST_MASK_STOP: assert property (@(posedge MCLK) disable iff (!RST_B)
      kick && !wr_ev
      |=> s_ff.ev[emsc_pkg::BIT_RCOM] == $past(s_ff.ev[emsc_pkg::BIT_RCOM]))
      else $error("mask changed by stop");

   // Transmit-begun flag and its mask.
   AST_TXB_SET: assert property (@(posedge MCLK) disable iff (!RST_B)
      TX_START
      |=> s_ff.ev[emsc_pkg::BIT_TXB])
      else $error("transmit flag not set");

   AST_TXB_IRQ: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_ff.ev[emsc_pkg::BIT_TXB] && !s_ff.ev[emsc_pkg::BIT_TXBM] && s_ff.interrupt_output_enable
      |-> IRQ)
      else $error("unmasked transmit flag without irq");

   AST_IRQ_OFF: assert property (@(posedge MCLK) disable iff (!RST_B)
      !s_ff.interrupt_output_enable
      |-> !IRQ)
      else $error("irq while disabled");

   AST_IRQ: assert property (@(posedge MCLK) disable iff (!RST_B)
      ##1 IRQ == $past(interrupt_summary_flag && nxt_s.interrupt_output_enable))
      else $error("irq mismatch");

   AST_W1C: assert property (@(posedge MCLK) disable iff (!RST_B)
      wr_ev && WDATA[emsc_pkg::BIT_TXB] && !TX_START
      |=> !s_ff.ev[emsc_pkg::BIT_TXB])
      else $error("write one did not clear");

   AST_TXB_W0: assert property (@(posedge MCLK) disable iff (!RST_B)
      wr_ev && !WDATA[emsc_pkg::BIT_TXB] && s_ff.ev[emsc_pkg::BIT_TXB] && !kick
      |=> s_ff.ev[emsc_pkg::BIT_TXB])
      else $error("transmit write zero cleared");

   AST_TXB_STOP: assert property (@(posedge MCLK) disable iff (!RST_B)
      kick && !TX_START
      |=> !s_ff.ev[emsc_pkg::BIT_TXB])
      else $error("transmit flag survived stop");

   AST_TXB_ONLY: assert property (@(posedge MCLK) disable iff (!RST_B)
      $rose(s_ff.ev[emsc_pkg::BIT_TXB])
      |-> $past(TX_START))
      else $error("transmit flag set without frame start");

   AST_TXBM_GATE: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_ff.ev[emsc_pkg::BIT_TXBM] && !s_ff.ev[emsc_pkg::BIT_RCO] && !s_ff.ev[emsc_pkg::BIT_JAB]
      |-> !IRQ)
      else $error("masked transmit flag raised irq");

   AST_TXBM_KEEP: assert property (@(posedge MCLK) disable iff (!RST_B)
      kick && !wr_ev
      |=> s_ff.ev[emsc_pkg::BIT_TXBM] == $past(s_ff.ev[emsc_pkg::BIT_TXBM]))
      else $error("transmit mask changed by stop");

   // Runaway flag and its mask.
   AST_JAB_TP: assert property (@(posedge MCLK) disable iff (!RST_B)
      $rose(s_ff.ev[emsc_pkg::BIT_JAB])
      |-> $past(TP_ACTIVE))
      else $error("runaway without twisted pair");

   AST_JAB_SET: assert property (@(posedge MCLK) disable iff (!RST_B)
      JABBER && TP_ACTIVE && !s_ff.jab_prev
      |=> s_ff.ev[emsc_pkg::BIT_JAB])
      else $error("runaway flag not set");

   AST_JAB_IRQ: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_ff.ev[emsc_pkg::BIT_JAB] && !s_ff.ev[emsc_pkg::BIT_TRANSMIT_RUNAWAY_MASK] && s_ff.interrupt_output_enable
      |-> IRQ)
      else $error("unmasked runaway without irq");

   AST_JAB_W1C: assert property (@(posedge MCLK) disable iff (!RST_B)
      wr_ev && WDATA[emsc_pkg::BIT_JAB] && s_ff.jab_prev && JABBER && TP_ACTIVE
      |=> !s_ff.ev[emsc_pkg::BIT_JAB])
      else $error("runaway not cleared while persisting");

   AST_W0_KEEP: assert property (@(posedge MCLK) disable iff (!RST_B)
      wr_ev && !WDATA[emsc_pkg::BIT_JAB] && s_ff.ev[emsc_pkg::BIT_JAB] && !kick
      |=> s_ff.ev[emsc_pkg::BIT_JAB])
      else $error("write zero cleared");

   AST_JAB_STOP: assert property (@(posedge MCLK) disable iff (!RST_B)
      kick && !(JABBER && TP_ACTIVE && !s_ff.jab_prev)
      |=> !s_ff.ev[emsc_pkg::BIT_JAB])
      else $error("runaway survived stop");

   AST_TRANSMIT_RUNAWAY_MASK_GATE: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_ff.ev[emsc_pkg::BIT_TRANSMIT_RUNAWAY_MASK] && !s_ff.ev[emsc_pkg::BIT_RCO] && !s_ff.ev[emsc_pkg::BIT_TXB]
      |-> !IRQ)
      else $error("masked runaway raised irq");

   AST_TRANSMIT_RUNAWAY_MASK_KEEP: assert property (@(posedge MCLK) disable iff (!RST_B)
      kick && !wr_ev
      |=> s_ff.ev[emsc_pkg::BIT_TRANSMIT_RUNAWAY_MASK] == $past(s_ff.ev[emsc_pkg::BIT_TRANSMIT_RUNAWAY_MASK]))
      else $error("runaway mask changed by stop");

   // Read port.
   AST_RES: assert property (@(posedge MCLK) disable iff (!RST_B)
      $past(RD) && $past(ADDR) == emsc_pkg::ADDR_EVENT
      |-> RDATA[15:6] == 10'h000)
      else $error("reserved bits nonzero");

   AST_RD_IDLE: assert property (@(posedge MCLK) disable iff (!RST_B)
      !$past(RD)
      |-> RDATA == 16'h0000)
      else $error("read data without read");

   AST_SUMMARY: assert property (@(posedge MCLK) disable iff (!RST_B)
      $past(RD) && $past(ADDR) == emsc_pkg::ADDR_CTRL0 && $past(s_ff.interrupt_output_enable)
      |-> RDATA[emsc_pkg::BIT_INTERRUPT_SUMMARY_FLAG] == $past(IRQ))
      else $error("summary read disagrees with irq");

   // Suspend sequence.
   AST_SUSPEND_REQUEST_READ: assert property (@(posedge MCLK) disable iff (!RST_B)
      $past(RD) && $past(ADDR) == emsc_pkg::ADDR_CTRL1
      |-> RDATA[emsc_pkg::BIT_SUSPEND] == $past(SUSPENDED))
      else $error("suspend read-back wrong");

   AST_SUSPEND_REQUEST_STOP: assert property (@(posedge MCLK) disable iff (!RST_B)
      s_ff.stop && !wr_c0
      |=> !s_ff.suspend_request_req)
      else $error("suspend while stopped");

   AST_RESUME: assert property (@(posedge MCLK) disable iff (!RST_B)
      wr_c1 && !WDATA[emsc_pkg::BIT_SUSPEND]
      |=> !SUSPENDED && !HOLD_RINGS)
      else $error("written zero did not resume");

   AST_KICK: assert property (@(posedge MCLK) disable iff (!RST_B)
      kick
      |=> !SUSPENDED && !HOLD_RINGS)
      else $error("suspend survived stop");

   AST_TX_FIRST: assert property (@(posedge MCLK) disable iff (!RST_B)
      $rose(s_ff.st == emsc_pkg::EMSC_RX_DRAIN)
      |-> $past(!TX_BUSY))
      else $error("receive drain before transmit finished");

   AST_DRAIN: assert property (@(posedge MCLK) disable iff (!RST_B)
      $rose(SUSPENDED)
      |-> $past(!RX_BUSY))
      else $error("suspended while receiving");

   AST_RX_BLOCK: assert property (@(posedge MCLK) disable iff (!RST_B)
      RX_BLOCK
      |-> s_ff.suspend_request_req)
      else $error("receiver blocked without request");

   AST_HOLD: assert property (@(posedge MCLK) disable iff (!RST_B)
      SUSPENDED
      |-> HOLD_RINGS)
      else $error("rings moving while suspended");

   CV_SUSPEND: cover property (@(posedge MCLK) disable iff (!RST_B) $rose(SUSPENDED));
   CV_IRQ: cover property (@(posedge MCLK) disable iff (!RST_B) $rose(IRQ));
   CV_RESUME: cover property (@(posedge MCLK) disable iff (!RST_B) $fell(SUSPENDED));
   CV_JAB_HELD: cover property (@(posedge MCLK) disable iff (!RST_B)
      wr_ev && WDATA[emsc_pkg::BIT_JAB] && s_ff.jab_prev && JABBER);
   CV_REFUSED: cover property (@(posedge MCLK) disable iff (!RST_B)
      wr_c1 && WDATA[emsc_pkg::BIT_SUSPEND] && s_ff.stop);
endmodule

// ---- sim/emsc_host.sv ----
// Host software model that drives the register port.
// Assumes the block's clock and its registered read data.
module emsc_host (
   input wire logic MCLK,
   input wire logic [15:0] RDATA,
   output logic [3:0] ADDR,
   output logic [15:0] WDATA,
   output logic WR,
   output logic RD
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ADDR = 4'h0;
      WDATA = 16'h0000;
      WR = 1'b0;
      RD = 1'b0;
   end
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      @(posedge MCLK);
      v = RDATA;
   endtask
   task automatic poll(output logic ok);
      logic [15:0] v;
      ok = 1'b0;
      for (int i = 0; i < 20 && ok !== 1'b1; i++) begin
         rd(emsc_pkg::ADDR_CTRL1, v);
         ok = v[emsc_pkg::BIT_SUSPEND];
      end
   endtask
endmodule

// ---- sim/tb.sv ----
// Testbench: drives events and busy levels, judges flags and suspend.
// Assumes the host model for all register traffic.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] EV = emsc_pkg::ADDR_EVENT;
   localparam logic [3:0] C1 = emsc_pkg::ADDR_CTRL1;
   localparam logic [3:0] C0 = emsc_pkg::ADDR_CTRL0;
   logic MCLK = 1'b0, RST_B = 1'b0, TP_ACTIVE = 1'b0, TX_BUSY = 1'b0, RX_BUSY = 1'b0, ok;
   logic [2:0] ev = 3'b000;
   logic IRQ, SUSPENDED, RX_BLOCK, HOLD_RINGS, STOP_OUT, WR, RD;
   logic [3:0] ADDR;
   logic [15:0] WDATA, RDATA, d;
   int num_errors = 0;
   int cmp_count = 0;
   emsc_host host (.MCLK(MCLK), .RDATA(RDATA), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD));
   emsc_top dut (.MCLK(MCLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .COLL_WRAP(ev[2]), .TX_START(ev[1]), .JABBER(ev[0]),
      .TP_ACTIVE(TP_ACTIVE), .TX_BUSY(TX_BUSY), .RX_BUSY(RX_BUSY), .IRQ(IRQ),
      .SUSPENDED(SUSPENDED), .RX_BLOCK(RX_BLOCK), .HOLD_RINGS(HOLD_RINGS), .STOP_OUT(STOP_OUT));
   initial begin
      forever #4 MCLK = ~MCLK;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
      host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic pulse(input logic [2:0] m);
      @(posedge MCLK);
      ev <= m;
      @(posedge MCLK);
      ev <= 3'b000;
   endtask
   task automatic print_verdict;
      $display("Errors %0d, comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic t_flags;
      chk({12'h000, IRQ, SUSPENDED, STOP_OUT, RX_BLOCK}, 16'h0002);
      rdchk(EV, 16'h0015);
      pulse(3'b001);
      rdchk(EV, 16'h0015);
      TP_ACTIVE <= 1'b1;
      pulse(3'b111);
      rdchk(EV, 16'h003F);
      chk({15'h0000, IRQ}, 16'h0000);
   endtask
   task automatic t_irq;
      host.wr(C0, 16'h0040);
      host.wr(EV, 16'h0000);
      rdchk(EV, 16'h002A);
      chk({15'h0000, IRQ}, 16'h0001);
      host.wr(EV, 16'h0022);
      rdchk(EV, 16'h0008);
      chk({15'h0000, IRQ}, 16'h0001);
      host.wr(EV, 16'h0004);
      @(negedge MCLK);
      chk({15'h0000, IRQ}, 16'h0000);
      host.wr(EV, 16'h000B);
      rdchk(EV, 16'h0001);
      ev <= 3'b001;
      host.wr(EV, 16'h0003);
      rdchk(EV, 16'h0001);
      ev <= 3'b000;
   endtask
   task automatic t_suspend;
      TX_BUSY <= 1'b1;
      RX_BUSY <= 1'b1;
      host.wr(C1, 16'h0001);
      rdchk(C1, 16'h0000);
      TX_BUSY <= 1'b0;
      rdchk(C1, 16'h0000);
      chk({15'h0000, HOLD_RINGS}, 16'h0001);
      RX_BUSY <= 1'b0;
      host.poll(ok);
      chk({13'h0000, SUSPENDED, RX_BLOCK, HOLD_RINGS}, {13'h0000, ok, 2'b11});
      host.wr(EV, 16'h0015);
      rdchk(EV, 16'h0015);
      host.wr(C1, 16'h0000);
      @(posedge MCLK);
      chk({14'h0000, SUSPENDED, HOLD_RINGS}, 16'h0000);
   endtask
   task automatic t_stop;
      pulse(3'b100);
      host.wr(C1, 16'h0001);
      host.poll(ok);
      host.wr(C0, 16'h0044);
      @(posedge MCLK);
      chk({14'h0000, SUSPENDED, STOP_OUT}, {15'h0000, ok});
      rdchk(EV, 16'h0015);
      host.wr(C1, 16'h0001);
      rdchk(C1, 16'h0000);
      host.wr(C0, 16'h0040);
      host.wr(C1, 16'h0001);
      host.poll(ok);
      host.rd(emsc_pkg::ADDR_RESET_REG, d);
      @(posedge MCLK);
      chk({15'h0000, SUSPENDED}, {15'h0000, ~ok});
   endtask
   initial begin
      repeat (5) @(posedge MCLK);
      RST_B <= 1'b1;
      t_flags();
      t_irq();
      t_suspend();
      t_stop();
      print_verdict();
   end
endmodule
